// ==== hdl/tsio_port.sv ====
// Overview of operation
// - Ports of several widths, here a 1-bit and a 4-bit port, map onto fixed pins.
// - Each port is wholly input or wholly output, one direction for all its pins.
// - Ports drive pins or sample them, optionally waiting for a pin condition.
// - Every processor command to a port is taken and finished in one cycle.
// - Open drain: a zero drives the pin low, a one releases it.
// - Open drain is chosen per port and applies to all its pins.
// - Data passes through a shift register plus a transfer register.
// - Each port has a 16-bit counter that schedules transfers.
// - Counter is always readable; a target count defers the next transfer.
// - Each transfer captures the counter value as a readable timestamp.
// - An enabled serial link releases the pins it shares from port drivers; input ports still sample them.
// - An enabled narrower port owns shared pins ahead of a wider port.
// - Pins not shared with the narrower port stay with the wider port.
// - A port always transfers its full width even when pins are claimed.
// - Six clock blocks; block zero is the reference clock, five are programmable.
// - A clock block may take the 1-bit port pin as source, with divider.
// - Ports accept an incoming strobe and drive an outgoing strobe with data.
// - After reset every port is attached to clock block zero.
// - Pin events go straight to the core scheduler as pulses, not interrupts.
`default_nettype none
module tsio_port (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire tsio_pkg::tsio_port_cfg_t [tsio_pkg::NUM_PORTS-1:0] PORT_CFG_I,
  input wire tsio_pkg::tsio_cmd_t [tsio_pkg::NUM_PORTS-1:0] PORT_CMD_I,
  input wire tsio_pkg::tsio_cb_cfg_t [tsio_pkg::NUM_CB-1:1] CB_CFG_I,
  input wire logic LINK_EN_I,
  input wire logic [tsio_pkg::NUM_PINS-1:0] PIN_I,
  input wire logic STROBE_IN_I,
  output logic [tsio_pkg::NUM_PINS-1:0] PIN_O,
  output logic [tsio_pkg::NUM_PINS-1:0] PIN_OE_O,
  output logic [tsio_pkg::NUM_PORTS-1:0] STROBE_OUT_O,
  output logic [tsio_pkg::NUM_PORTS-1:0] EVENT_O,
  output tsio_pkg::tsio_status_t [tsio_pkg::NUM_PORTS-1:0] PORT_STATUS_O
);

  logic [tsio_pkg::NUM_CB-1:0] tick_vec;

  // Block zero runs at the core reference rate, so it ticks every cycle
  assign tick_vec[0] = 1'b1;

  genvar c;
  generate
    for (c = 1; c < tsio_pkg::NUM_CB; c++) begin : g_cb
      logic [tsio_pkg::DIV_W-1:0] div_cnt_q, div_cnt_d;
      logic prev_q, prev_d, tick_q, tick_d, src_evt;
      always_comb begin
        prev_d = PIN_I[tsio_pkg::CB_SRC_PIN];
        div_cnt_d = div_cnt_q;
        tick_d = 1'b0;
        // External source counts rising edges of the 1-bit port pin
        src_evt = CB_CFG_I[c].src_pin ? (PIN_I[tsio_pkg::CB_SRC_PIN] & ~prev_q)
          : 1'b1;
        if (src_evt) begin
          if (div_cnt_q >= CB_CFG_I[c].div) begin
            div_cnt_d = tsio_pkg::DIV_RST;
            tick_d = 1'b1;
          end else begin
            div_cnt_d = div_cnt_q + 1'b1;
          end
        end
      end
      always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
          div_cnt_q <= tsio_pkg::DIV_RST;
          prev_q <= 1'b0;
          tick_q <= 1'b0;
        end else begin
          div_cnt_q <= div_cnt_d;
          prev_q <= prev_d;
          tick_q <= tick_d;
        end
      end
      assign tick_vec[c] = tick_q;
    end
  endgenerate

  genvar g;
  generate
    for (g = 0; g < tsio_pkg::NUM_PORTS; g++) begin : g_port
      localparam int W = (g == 0) ? tsio_pkg::PORT_W0 : tsio_pkg::PORT_W1;
      localparam logic [tsio_pkg::XFER_W-1:0] WMASK = tsio_pkg::XFER_W'((1 << W) - 1);
      localparam logic [tsio_pkg::SHCNT_W-1:0] N_SER = tsio_pkg::SHCNT_W'(tsio_pkg::XFER_W / W);
      tsio_pkg::tsio_port_cfg_t cfg;
      tsio_pkg::tsio_cmd_t cmd;
      logic [tsio_pkg::CNT_W-1:0] cnt_q, cnt_d, tgt_q, tgt_d, stamp_q, stamp_d;
      logic [tsio_pkg::XFER_W-1:0] xfer_q, xfer_d, shift_q, shift_d, rdata_q, rdata_d;
      logic [tsio_pkg::XFER_W-1:0] pins_w;
      logic [tsio_pkg::SHCNT_W-1:0] shcnt_q, shcnt_d, nwords;
      logic [tsio_pkg::CB_SEL_W-1:0] sel_q, sel_d;
      logic [tsio_pkg::NUM_PINS-1:0] drv_q, drv_d;
      logic full_q, full_d, armed_q, armed_d, evt_q, evt_d, stb_q, stb_d;
      logic valid_q, valid_d, busy_q, busy_d;
      logic tick, go, cond_ok;
      assign cfg = PORT_CFG_I[g];
      assign cmd = PORT_CMD_I[g];
      // Full width is sampled even where another port owns a pin
      assign pins_w = tsio_pkg::XFER_W'(PIN_I) & WMASK;

      always_comb begin
        cnt_d = cnt_q;
        tgt_d = tgt_q;
        stamp_d = stamp_q;
        xfer_d = xfer_q;
        shift_d = shift_q;
        rdata_d = rdata_q;
        shcnt_d = shcnt_q;
        sel_d = sel_q;
        drv_d = drv_q;
        full_d = full_q;
        armed_d = armed_q;
        evt_d = 1'b0;
        stb_d = 1'b0;
        nwords = cfg.serial ? N_SER : 4'h1;
        tick = (sel_q < tsio_pkg::CB_SEL_W'(tsio_pkg::NUM_CB)) ? tick_vec[sel_q] : 1'b1;
        // A pending target holds off the start of an output transfer and every input sample
        go = tick && cfg.en && (!armed_q || cnt_q == tgt_q);
        cond_ok = !cfg.cond_en
          || (pins_w == (tsio_pkg::XFER_W'(cfg.cond_val) & WMASK));
        if (cfg.stb_in_en && !STROBE_IN_I) begin
          cond_ok = 1'b0;
        end
        if (cmd.set_clk) begin
          sel_d = cfg.cb_sel;
        end
        if (tick) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (cfg.dir_out) begin
          if (go && shcnt_q == tsio_pkg::SHCNT_RST && full_q) begin
            drv_d = tsio_pkg::NUM_PINS'(xfer_q & WMASK);
            shift_d = xfer_q >> W;
            shcnt_d = nwords - 1'b1;
            full_d = 1'b0;
            stamp_d = cnt_q;
            armed_d = 1'b0;
            stb_d = 1'b1;
          end else if (tick && cfg.en && shcnt_q != tsio_pkg::SHCNT_RST) begin
            drv_d = tsio_pkg::NUM_PINS'(shift_q & WMASK);
            shift_d = shift_q >> W;
            shcnt_d = shcnt_q - 1'b1;
            stb_d = 1'b1;
          end
          // A write in the cycle the register empties is kept, not lost
          if (cmd.wr) begin
            xfer_d = cmd.data;
            full_d = 1'b1;
          end
        end else begin
          if (cmd.rd) begin
            rdata_d = xfer_q;
            full_d = 1'b0;
          end
          if (go && (cond_ok || shcnt_q != tsio_pkg::SHCNT_RST)
              && (!cfg.stb_in_en || STROBE_IN_I)) begin
            shift_d = (shift_q >> W) | tsio_pkg::XFER_W'(pins_w << (tsio_pkg::XFER_W - W));
            shcnt_d = (shcnt_q == tsio_pkg::SHCNT_RST) ? nwords - 1'b1 : shcnt_q - 1'b1;
            if (shcnt_d == tsio_pkg::SHCNT_RST) begin
              xfer_d = cfg.serial ? shift_d : pins_w;
              full_d = 1'b1;
              stamp_d = cnt_q;
              armed_d = 1'b0;
              evt_d = 1'b1;
            end
          end
        end
        // A target given in the cycle a transfer consumes the old one stays armed
        if (cmd.set_time) begin
          tgt_d = cmd.tgt;
          armed_d = 1'b1;
        end
        valid_d = full_d & ~cfg.dir_out;
        busy_d = (full_d & cfg.dir_out) | (shcnt_d != tsio_pkg::SHCNT_RST);
      end

      always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
          cnt_q <= tsio_pkg::CNT_RST;
          tgt_q <= tsio_pkg::CNT_RST;
          stamp_q <= tsio_pkg::CNT_RST;
          xfer_q <= tsio_pkg::XFER_RST;
          shift_q <= tsio_pkg::XFER_RST;
          rdata_q <= tsio_pkg::XFER_RST;
          shcnt_q <= tsio_pkg::SHCNT_RST;
          sel_q <= tsio_pkg::CB_SEL_RST;
          drv_q <= '0;
          valid_q <= 1'b0;
          busy_q <= 1'b0;
          full_q <= 1'b0;
          armed_q <= 1'b0;
          evt_q <= 1'b0;
          stb_q <= 1'b0;
        end else begin
          cnt_q <= cnt_d;
          tgt_q <= tgt_d;
          stamp_q <= stamp_d;
          xfer_q <= xfer_d;
          shift_q <= shift_d;
          rdata_q <= rdata_d;
          shcnt_q <= shcnt_d;
          sel_q <= sel_d;
          drv_q <= drv_d;
          valid_q <= valid_d;
          busy_q <= busy_d;
          full_q <= full_d;
          armed_q <= armed_d;
          evt_q <= evt_d;
          stb_q <= stb_d;
        end
      end

      assign EVENT_O[g] = evt_q;
      assign STROBE_OUT_O[g] = stb_q;
      assign PORT_STATUS_O[g].rdata = rdata_q;
      assign PORT_STATUS_O[g].data_valid = valid_q;
      assign PORT_STATUS_O[g].tx_busy = busy_q;
      assign PORT_STATUS_O[g].cb_sel = sel_q;
      assign PORT_STATUS_O[g].count = cnt_q;
      assign PORT_STATUS_O[g].stamp = stamp_q;
    end
  endgenerate

  logic [tsio_pkg::NUM_PINS-1:0] pin_q, pin_d, oe_q, oe_d;
  logic owner;
  logic bitv;
  logic drives;

  // Pin ownership: link first, then the narrow port, then the wide port
  always_comb begin
    pin_d = '0;
    oe_d = '0;
    owner = 1'b0;
    bitv = 1'b0;
    drives = 1'b0;
    for (int i = 0; i < tsio_pkg::NUM_PINS; i++) begin
      owner = (i == tsio_pkg::NARROW_PIN) && PORT_CFG_I[0].en;
      bitv = owner ? g_port[0].drv_q[0] : g_port[1].drv_q[i];
      drives = owner ? PORT_CFG_I[0].dir_out : (PORT_CFG_I[1].en && PORT_CFG_I[1].dir_out);
      if (LINK_EN_I && i >= tsio_pkg::LINK_PIN_LO) begin
        oe_d[i] = 1'b0;
      end else if (drives) begin
        if (owner ? PORT_CFG_I[0].open_drain : PORT_CFG_I[1].open_drain) begin
          oe_d[i] = ~bitv;
        end else begin
          oe_d[i] = 1'b1;
          pin_d[i] = bitv;
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pin_q <= '0;
      oe_q <= '0;
    end else begin
      pin_q <= pin_d;
      oe_q <= oe_d;
    end
  end

  assign PIN_O = pin_q;
  assign PIN_OE_O = oe_q;

endmodule // tsio_port
`default_nettype wire

// ==== include/tsio_pkg.sv ====
`default_nettype none
package tsio_pkg;
  localparam int NUM_PORTS = 2;
  localparam int NUM_PINS = 4;
  localparam int NUM_CB = 6;
  localparam int XFER_W = 8;
  localparam int CNT_W = 16;
  localparam int CB_SEL_W = 3;
  localparam int DIV_W = 8;
  localparam int SHCNT_W = 4;
  // Port 0 is the narrow 1-bit port on pin 0, port 1 the wide 4-bit port on pins 3..0
  localparam int PORT_W0 = 1;
  localparam int PORT_W1 = 4;
  localparam int NARROW_PIN = 0;
  localparam int CB_SRC_PIN = 0;
  // The serial link claims pins from this index upward
  localparam int LINK_PIN_LO = 2;
  localparam logic [CB_SEL_W-1:0] CB_SEL_RST = 3'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [XFER_W-1:0] XFER_RST = 8'h00;
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
  localparam logic [SHCNT_W-1:0] SHCNT_RST = 4'h0;

  typedef struct packed {
    logic en;
    logic dir_out;
    logic open_drain;
    logic cond_en;
    logic [NUM_PINS-1:0] cond_val;
    logic serial;
    logic stb_in_en;
    logic [CB_SEL_W-1:0] cb_sel;
  } tsio_port_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic set_time;
    logic set_clk;
    logic [XFER_W-1:0] data;
    logic [CNT_W-1:0] tgt;
  } tsio_cmd_t;

  typedef struct packed {
    logic src_pin;
    logic [DIV_W-1:0] div;
  } tsio_cb_cfg_t;

  typedef struct packed {
    logic [XFER_W-1:0] rdata;
    logic data_valid;
    logic tx_busy;
    logic [CB_SEL_W-1:0] cb_sel;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] stamp;
  } tsio_status_t;
endpackage
`default_nettype wire

// ==== verification/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, nrst, link_en, stb_in;
  tsio_pkg::tsio_port_cfg_t [1:0] cfg;
  tsio_pkg::tsio_cmd_t [1:0] cmd;
  tsio_pkg::tsio_cb_cfg_t [5:1] cb;
  tsio_pkg::tsio_status_t [1:0] st;
  logic [3:0] pin_i, pin_o, pin_oe, ext_val, ext_oe, seen;
  logic [1:0] stb_out, evt;
  int num_errors = 0;
  int num_checks = 0;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  tsio_port tsio_port_inst (.CORE_CLK_I(clk), .NRST_I(nrst), .PORT_CFG_I(cfg),
    .PORT_CMD_I(cmd), .CB_CFG_I(cb), .LINK_EN_I(link_en), .PIN_I(pin_i), .STROBE_IN_I(stb_in),
    .PIN_O(pin_o), .PIN_OE_O(pin_oe), .STROBE_OUT_O(stb_out), .EVENT_O(evt),
    .PORT_STATUS_O(st));
  tsio_pin_model tsio_pin_model_inst (.clk_i(clk), .nrst_i(nrst), .pin_o_i(pin_o),
    .pin_oe_i(pin_oe), .ext_val_i(ext_val), .ext_oe_i(ext_oe), .stb_word_i(stb_out[1]),
    .pin_lvl_o(pin_i), .seen_o(seen));
  task automatic chk(string name, logic [31:0] seen_v, logic [31:0] exp_v);
    num_checks++;
    if (seen_v !== exp_v) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp_v, seen_v);
    end
  endtask
  task automatic tk(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic iss(int p, tsio_pkg::tsio_cmd_t c);
    cmd[p] = c;
    tk(1);
    cmd[p] = '0;
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic rst_cycle();
    nrst = 1'b0;
    tk(12);
    chk("cb_sel0", st[0].cb_sel, 0);
    chk("cb_sel1", st[1].cb_sel, 0);
    chk("count", st[1].count, 0);
    nrst = 1'b1;
    tk(2);
  endtask
  task automatic t_out(logic [7:0] d, logic od, logic p0, logic lk, logic [3:0] m);
    logic [15:0] c1;
    cfg[1].open_drain = od;
    cfg[0] = '{en: p0, open_drain: od, default: '0};
    link_en = lk;
    tk(3);
    iss(1, '{wr: 1'b1, data: d, default: '0});
    chk("tx_busy", st[1].tx_busy, 1);
    c1 = st[1].count;
    tk(1);
    chk("strobe_out", stb_out[1], 1);
    chk("stamp", st[1].stamp, c1);
    tk(1);
    chk("pin_oe", pin_oe, od ? ~d[3:0] & m : m);
    tk(1);
    chk("pin_level", seen, od ? 4'h0 : d[3:0] & m);
  endtask
  // Narrow output port on pin 0 beside the wide port shifting two nibbles
  task automatic t_narrow();
    cfg[0] = '{en: 1'b1, dir_out: 1'b1, default: '0};
    cfg[1] = '{en: 1'b1, dir_out: 1'b1, serial: 1'b1, default: '0};
    link_en = 1'b0;
    tk(2);
    cmd[0] = '{wr: 1'b1, data: 8'h00, default: '0};
    cmd[1] = '{wr: 1'b1, data: 8'hC3, default: '0};
    tk(1);
    cmd = '0;
    tk(1);
    chk("strobe_both", stb_out, 2'h3);
    tk(1);
    chk("narrow_pin", pin_o, 4'h2);
    chk("narrow_oe", pin_oe, 4'hF);
    tk(1);
    chk("nibble0", seen, 4'h2);
    tk(1);
    chk("nibble1", seen, 4'hC);
  endtask
  task automatic t_in();
    logic [7:0] d;
    int k;
    d = 8'hB5;
    cfg[1] = '0;
    cfg[0] = '{en: 1'b1, cond_en: 1'b1, cond_val: 4'h1, serial: 1'b1, stb_in_en: 1'b1,
      default: '0};
    ext_oe = 4'h1;
    stb_in = 1'b1;
    tk(2);
    iss(0, '{rd: 1'b1, default: '0});
    tk(2);
    // Mid-word gap with the wrong level and no strobe must not be sampled
    for (k = 0; k < 9; k++) begin
      stb_in = k != 4;
      ext_val = {3'h0, k == 4 ? ~d[4] : d[k - (k > 4)]};
      tk(1);
    end
    stb_in = 1'b0;
    ext_val = 4'h0;
    for (k = 0; k < 20 && evt[0] !== 1'b1; k++) tk(1);
    chk("event", evt[0], 1);
    chk("valid", st[0].data_valid, 1);
    iss(0, '{rd: 1'b1, default: '0});
    chk("rdata", st[0].rdata, d);
    chk("valid_clr", st[0].data_valid, 0);
    ext_oe = 4'h0;
  endtask
  task automatic t_timed();
    logic [15:0] tg;
    int k;
    cfg[1] = '{en: 1'b1, dir_out: 1'b1, default: '0};
    tg = st[1].count + 16'h0014;
    iss(1, '{set_time: 1'b1, tgt: tg, default: '0});
    // Let an edge pass so the command word is not rewritten in one time step
    tk(1);
    iss(1, '{wr: 1'b1, data: 8'h3C, default: '0});
    // Count reaches the target twenty edges after it was read, three already spent
    for (k = 0; k < 40 && stb_out[1] !== 1'b1; k++) tk(1);
    chk("timed_stamp", st[1].stamp, tg);
    chk("timed_wait", k, 18);
  endtask
  task automatic t_clk();
    logic [15:0] c0;
    int k;
    cfg[0] = '0;
    cfg[1] = '{en: 1'b1, cb_sel: 3'h5, default: '0};
    cb[5] = '{src_pin: 1'b1, div: 8'h01};
    ext_oe = 4'h1;
    iss(1, '{set_clk: 1'b1, default: '0});
    chk("cb_sel", st[1].cb_sel, 5);
    c0 = st[1].count;
    // Four rising pin edges, divided by two, give two counter ticks
    for (k = 0; k < 16; k++) begin
      ext_val = {3'h0, k[1]};
      tk(1);
    end
    tk(3);
    chk("ext_count", st[1].count, c0 + 16'h0002);
  endtask
  initial begin
    tk(3000);
    num_errors++;
    complete_run();
  end
  initial begin
    nrst = 1'b0;
    link_en = 1'b0;
    stb_in = 1'b0;
    cfg = '0;
    cmd = '0;
    cb = '0;
    ext_val = 4'h0;
    ext_oe = 4'h0;
    rst_cycle();
    cfg[1] = '{en: 1'b1, dir_out: 1'b1, default: '0};
    t_out(8'hA5, 1'b0, 1'b0, 1'b0, 4'hF);
    t_out(8'h06, 1'b1, 1'b0, 1'b0, 4'hF);
    t_out(8'h0F, 1'b0, 1'b1, 1'b0, 4'hE);
    t_out(8'h0F, 1'b0, 1'b0, 1'b1, 4'h3);
    t_narrow();
    t_in();
    t_timed();
    t_clk();
    rst_cycle();
    complete_run();
  end
endmodule // testbench
bind tsio_port tsio_port_properties tsio_port_properties_inst (.CORE_CLK_I(CORE_CLK_I),
  .NRST_I(NRST_I), .PORT_CFG_I(PORT_CFG_I), .PORT_CMD_I(PORT_CMD_I), .LINK_EN_I(LINK_EN_I),
  .PIN_O(PIN_O), .PIN_OE_O(PIN_OE_O), .STROBE_OUT_O(STROBE_OUT_O),
  .PORT_STATUS_O(PORT_STATUS_O));
`default_nettype wire

// ==== verification/tsio_pin_model.sv ====
`default_nettype none
module tsio_pin_model (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [3:0] pin_o_i,
  input wire logic [3:0] pin_oe_i,
  input wire logic [3:0] ext_val_i,
  input wire logic [3:0] ext_oe_i,
  input wire logic stb_word_i,
  output logic [3:0] pin_lvl_o,
  output logic [3:0] seen_o
);
  logic stb_q;
  // Nobody driving means the pull-down wins, so a released open-drain pin reads low
  assign pin_lvl_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_oe_i & ext_val_i);
  // Pins lag the outgoing strobe by one cycle, so the word is taken then
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stb_q <= 1'b0;
      seen_o <= 4'h0;
    end else begin
      stb_q <= stb_word_i;
      if (stb_q) seen_o <= pin_lvl_o;
    end
  end
endmodule // tsio_pin_model
`default_nettype wire

// ==== verification/tsio_port_properties.sv ====
`default_nettype none
module tsio_port_properties (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire tsio_pkg::tsio_port_cfg_t [tsio_pkg::NUM_PORTS-1:0] PORT_CFG_I,
  input wire tsio_pkg::tsio_cmd_t [tsio_pkg::NUM_PORTS-1:0] PORT_CMD_I,
  input wire logic LINK_EN_I,
  input wire logic [tsio_pkg::NUM_PINS-1:0] PIN_O,
  input wire logic [tsio_pkg::NUM_PINS-1:0] PIN_OE_O,
  input wire logic [tsio_pkg::NUM_PORTS-1:0] STROBE_OUT_O,
  input wire tsio_pkg::tsio_status_t [tsio_pkg::NUM_PORTS-1:0] PORT_STATUS_O
);
  default clocking core_cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  property p_link; LINK_EN_I [*2] |-> PIN_OE_O[3:2] == 2'h0; endproperty
  a_link: assert property (p_link) else $error("link pins driven");
  // Pin 0 may belong to the push-pull narrow port, so only pins 3..1 are judged
  property p_odrain; STROBE_OUT_O[1] && PORT_CFG_I[1].open_drain ##1 PORT_CFG_I[1].open_drain
    |-> (PIN_O & PIN_OE_O & 4'hE) == 4'h0; endproperty
  a_odrain: assert property (p_odrain) else $error("open drain drove high");
  property p_inpin; (PORT_CFG_I[0].en && !PORT_CFG_I[0].dir_out) [*3] |-> !PIN_OE_O[0];
  endproperty
  a_inpin: assert property (p_inpin) else $error("owned input pin driven");
  property p_strobe; STROBE_OUT_O[1] |-> $past(PORT_STATUS_O[1].tx_busy); endproperty
  a_strobe: assert property (p_strobe) else $error("strobe without word");
  property p_count; $past(NRST_I, 2) && PORT_STATUS_O[0].cb_sel == 3'h0
    |=> PORT_STATUS_O[0].count == $past(PORT_STATUS_O[0].count) + 16'h0001; endproperty
  a_count: assert property (p_count) else $error("counter did not step");
  property p_rdata; !PORT_CMD_I[0].rd |=> $stable(PORT_STATUS_O[0].rdata); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
  property p_cbsel; !PORT_CMD_I[1].set_clk |=> $stable(PORT_STATUS_O[1].cb_sel); endproperty
  a_cbsel: assert property (p_cbsel) else $error("clock select moved");
  property p_busy; PORT_CMD_I[1].wr && PORT_CFG_I[1].dir_out |=> PORT_STATUS_O[1].tx_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("write not taken");
endmodule // tsio_port_properties
`default_nettype wire
